// *** core/serial_pin_select_and_baud.sv ***
// Purpose: Pin select, data inversion and clock-synchronous bit-rate clock for two channels
// Assumes: APB slave on pclk; sub-clock tick input synchronous to pclk
// Notes: Registers at offsets 0x0 to 0xC; other addresses read zero
//
// Contract
// - The synchronous bit clock runs at phi / (4 x 2^(2n) x (N+1)) for n = 0, 2, 3 and sub-clock/2 / (4 x (N+1)) for n = 1, with N from 0 to 255.
// - The two-bit prescale select picks phi, sub-clock/2, phi/16 or phi/64 as divider input.
// - In sub-clock low-power states the channels run only when the CPU clock is sub-clock/2.
// - Control bits 7 and 6 always read one and ignore writes.
// - Bit 5 routes the shared pin to general I/O when 0 and to channel 2 transmit when 1.
// - Bit 4 routes the shared pin to general I/O or timer output when 0, channel 1 transmit when 1.
// - Bit 3 inverts the channel 2 transmit pin level when set.
// - Bit 2 inverts the channel 2 receive pin level when set.
// - Bit 1 inverts the channel 1 transmit pin level when set.
// - Bit 0 inverts the channel 1 receive pin level when set.
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_defines.svh"

module serial_pin_select_and_baud
#(
	parameter int PHI_HZ = 200000000
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sub_clk_tick,
	input wire logic low_power_mode,
	input wire logic cpu_on_sub_div2,
	input wire logic ch1_engine_tx,
	input wire logic ch2_engine_tx,
	output logic ch1_engine_rx,
	output logic ch2_engine_rx,
	input wire logic ch1_receive_line,
	input wire logic ch2_receive_line,
	input wire logic ch1_gpio_out,
	input wire logic timer_output_line,
	input wire logic timer_out_select,
	input wire logic ch2_gpio_out,
	output logic ch1_transmit_line,
	output logic ch2_transmit_line,
	output logic serial_run_allow,
	output logic sync_bit_tick,
	output logic sync_bit_clk
);

	logic [7:0] serial_pin_control_r;
	logic [7:0] baud_ctrl_r;
	logic [7:0] bit_rate_divisor_r;
	logic [5:0] pre_cnt_r;
	logic sub_half_r;
	logic [1:0] quarter_cnt_r;
	logic [7:0] div_cnt_r;
	logic sync_bit_clk_r;
	logic [31:0] prdata_r;
	serial_pin_pkg::pin_cfg_type cfg;
	serial_pin_pkg::prescale_type pre_sel;
	serial_pin_pkg::serial_lines_type eng;
	logic access;
	logic wr_en;
	logic addr_ok;
	logic pre_tick;
	logic quarter_tick;
	logic sync_en;
	logic [7:0] rd_mux;

	function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic lane);
		merge_byte = lane ? new_v : old_v;
	endfunction

	function automatic logic addr_known(input logic [`SP_ADDR_W-1:0] a);
		addr_known = (a == `SP_OFF_PIN_CTRL) || (a == `SP_OFF_BAUD_CTRL) ||
			(a == `SP_OFF_DIVISOR) || (a == `SP_OFF_STATUS);
	endfunction

	assign access = psel && penable && clk_en;
	assign addr_ok = (paddr[31:`SP_ADDR_W] == '0) && addr_known(paddr[`SP_ADDR_W-1:0]);
	assign wr_en = access && pwrite && addr_ok;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_r;

	// Pin control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serial_pin_control_r <= `SP_PIN_CTRL_RESET;
		else if (wr_en && paddr[`SP_ADDR_W-1:0] == `SP_OFF_PIN_CTRL)
			serial_pin_control_r <= merge_byte(serial_pin_control_r,
				pwdata[7:0] | `SP_PIN_CTRL_RO_MASK, pstrb[0]);
	end

	// Prescale and divisor registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			baud_ctrl_r <= `SP_BAUD_CTRL_RESET;
			bit_rate_divisor_r <= `SP_DIVISOR_RESET;
		end
		else if (wr_en)
		begin
			if (paddr[`SP_ADDR_W-1:0] == `SP_OFF_BAUD_CTRL)
				baud_ctrl_r <= merge_byte(baud_ctrl_r, {5'h00, pwdata[2:0]}, pstrb[0]);
			if (paddr[`SP_ADDR_W-1:0] == `SP_OFF_DIVISOR)
				bit_rate_divisor_r <= merge_byte(bit_rate_divisor_r, pwdata[7:0], pstrb[0]);
		end
	end

	always_comb
	begin
		rd_mux = 8'h00;
		unique case (paddr[`SP_ADDR_W-1:0])
			`SP_OFF_PIN_CTRL: rd_mux = serial_pin_control_r;
			`SP_OFF_BAUD_CTRL: rd_mux = baud_ctrl_r;
			`SP_OFF_DIVISOR: rd_mux = bit_rate_divisor_r;
			`SP_OFF_STATUS: rd_mux = {5'h00, sync_bit_clk_r, serial_run_allow, sync_en};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h00000000;
		else if (clk_en && psel && !penable && !pwrite)
			prdata_r <= addr_ok ? {24'h000000, rd_mux} : 32'h00000000;
	end

	assign cfg = serial_pin_pkg::pin_cfg_type'({serial_pin_control_r[`SP_BIT_CH2_TX_SEL],
		serial_pin_control_r[`SP_BIT_CH1_TX_SEL], serial_pin_control_r[`SP_BIT_CH2_TX_INV],
		serial_pin_control_r[`SP_BIT_CH2_RX_INV], serial_pin_control_r[`SP_BIT_CH1_TX_INV],
		serial_pin_control_r[`SP_BIT_CH1_RX_INV]});
	assign eng = '{ch1_tx: ch1_engine_tx, ch2_tx: ch2_engine_tx,
		ch1_rx: ch1_receive_line, ch2_rx: ch2_receive_line};

	// Pin routing with combinational inversion
	assign ch2_transmit_line = cfg.ch2_tx_pin_select ?
		(eng.ch2_tx ^ cfg.ch2_tx_invert) : ch2_gpio_out;
	assign ch1_transmit_line = cfg.ch1_tx_pin_select ?
		(eng.ch1_tx ^ cfg.ch1_tx_invert) :
		(timer_out_select ? timer_output_line : ch1_gpio_out);
	assign ch2_engine_rx = eng.ch2_rx ^ cfg.ch2_rx_invert;
	assign ch1_engine_rx = eng.ch1_rx ^ cfg.ch1_rx_invert;

	// Channels run in sub-clock states only on sub-clock/2 CPU clock
	assign serial_run_allow = !low_power_mode || cpu_on_sub_div2;
	assign sync_en = baud_ctrl_r[`SP_BIT_SYNC_EN] && serial_run_allow;
	assign pre_sel = serial_pin_pkg::prescale_type'({baud_ctrl_r[`SP_BIT_PRESCALE_HI],
		baud_ctrl_r[`SP_BIT_PRESCALE_LO]});

	// Prescaler input clock selection
	always_comb
	begin
		unique case (pre_sel)
			serial_pin_pkg::PRE_PHI: pre_tick = 1'b1;
			serial_pin_pkg::PRE_SUB_DIV2: pre_tick = sub_clk_tick && sub_half_r;
			serial_pin_pkg::PRE_PHI_DIV16:
				pre_tick = (pre_cnt_r[3:0] == 4'(`SP_PRE_N2_DIV - 1));
			serial_pin_pkg::PRE_PHI_DIV64:
				pre_tick = (pre_cnt_r == 6'(`SP_PRE_N3_DIV - 1));
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_cnt_r <= 6'h00;
			sub_half_r <= 1'b0;
		end
		else if (clk_en)
		begin
			pre_cnt_r <= sync_en ? pre_cnt_r + 6'h01 : 6'h00;
			if (sub_clk_tick)
				sub_half_r <= !sub_half_r;
		end
	end

	// Divide by N+1 then by 4 halves toggling the bit clock
	assign quarter_tick = sync_en && pre_tick && (div_cnt_r == bit_rate_divisor_r);
	assign sync_bit_tick = quarter_tick && (quarter_cnt_r == 2'(`SP_SYNC_MULT - 1));
	assign sync_bit_clk = sync_bit_clk_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt_r <= 8'h00;
			quarter_cnt_r <= 2'h0;
			sync_bit_clk_r <= 1'b1;
		end
		else if (clk_en)
		begin
			if (!sync_en)
			begin
				div_cnt_r <= 8'h00;
				quarter_cnt_r <= 2'h0;
				sync_bit_clk_r <= 1'b1;
			end
			else if (pre_tick)
			begin
				div_cnt_r <= quarter_tick ? 8'h00 : div_cnt_r + 8'h01;
				if (quarter_tick)
				begin
					quarter_cnt_r <= quarter_cnt_r + 2'h1;
					if (quarter_cnt_r[0])
						sync_bit_clk_r <= !sync_bit_clk_r;
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** core/serial_pin_defines.svh ***
// Purpose: Register offsets, field positions, reset values for serial pin select
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Header holds definitions only
`ifndef SERIAL_PIN_DEFINES_SVH
`define SERIAL_PIN_DEFINES_SVH

`define SP_ADDR_W 4
`define SP_OFF_PIN_CTRL 4'h0
`define SP_OFF_BAUD_CTRL 4'h4
`define SP_OFF_DIVISOR 4'h8
`define SP_OFF_STATUS 4'hC

`define SP_BIT_CH2_TX_SEL 5
`define SP_BIT_CH1_TX_SEL 4
`define SP_BIT_CH2_TX_INV 3
`define SP_BIT_CH2_RX_INV 2
`define SP_BIT_CH1_TX_INV 1
`define SP_BIT_CH1_RX_INV 0
`define SP_PIN_CTRL_RESET 8'hC0
`define SP_PIN_CTRL_RO_MASK 8'hC0

`define SP_BIT_PRESCALE_HI 1
`define SP_BIT_PRESCALE_LO 0
`define SP_BIT_SYNC_EN 2
`define SP_BAUD_CTRL_RESET 8'h00
`define SP_DIVISOR_RESET 8'h00

`define SP_SYNC_MULT 4
`define SP_PRE_N2_DIV 16
`define SP_PRE_N3_DIV 64

`endif

// *** core/serial_pin_pkg.sv ***
// Purpose: Types for serial pin select and bit-rate logic
// Assumes: Included before the top module
// Notes: Constants live in the defines header
package serial_pin_pkg;

	typedef enum logic [1:0]
	{
		PRE_PHI = 2'b00,
		PRE_SUB_DIV2 = 2'b01,
		PRE_PHI_DIV16 = 2'b10,
		PRE_PHI_DIV64 = 2'b11
	} prescale_type;

	typedef struct packed
	{
		logic ch2_tx_pin_select;
		logic ch1_tx_pin_select;
		logic ch2_tx_invert;
		logic ch2_rx_invert;
		logic ch1_tx_invert;
		logic ch1_rx_invert;
	} pin_cfg_type;

	typedef struct packed
	{
		logic ch1_tx;
		logic ch2_tx;
		logic ch1_rx;
		logic ch2_rx;
	} serial_lines_type;

endpackage

// *** test/serial_pin_assertions.sv ***
// Purpose: Port checks for pin select
// Assumes: Shadow of pin control from APB
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module serial_pin_assertions
(
	input wire logic pclk, presetn, clk_en, psel, penable, pwrite, pslverr,
	input wire logic [31:0] paddr, pwdata, prdata,
	input wire logic low_power_mode, cpu_on_sub_div2, sync_bit_tick, serial_run_allow,
	input wire logic ch1_engine_tx, ch2_engine_tx, ch1_engine_rx, ch2_engine_rx,
	input wire logic ch1_receive_line, ch2_receive_line, ch1_gpio_out, ch2_gpio_out,
	input wire logic timer_output_line, timer_out_select, ch1_transmit_line, ch2_transmit_line
);
	logic [5:0] sh_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sh_r <= 6'h00;
		else if (psel && penable && pwrite && clk_en && paddr == 32'h0)
			sh_r <= pwdata[5:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rsv_read_a: assert property (psel && !penable && !pwrite && clk_en && paddr == 32'h0
		|=> prdata[7:6] == 2'h3) else $error("reserved bits");
	ch2_route_a: assert property (ch2_transmit_line ==
		(sh_r[5] ? ch2_engine_tx ^ sh_r[3] : ch2_gpio_out)) else $error("ch2 tx");
	ch1_route_a: assert property (ch1_transmit_line == (sh_r[4] ? ch1_engine_tx ^ sh_r[1] :
		timer_out_select ? timer_output_line : ch1_gpio_out)) else $error("ch1 tx");
	rx2_inv_a: assert property (ch2_engine_rx == (ch2_receive_line ^ sh_r[2])) else $error("rx2");
	rx1_inv_a: assert property (ch1_engine_rx == (ch1_receive_line ^ sh_r[0])) else $error("rx1");
	run_ok_a: assert property (serial_run_allow == (!low_power_mode || cpu_on_sub_div2))
		else $error("run allow");
	tick_gap_a: assert property (sync_bit_tick |=> !sync_bit_tick [*3]) else $error("tick gap");
	bad_addr_a: assert property (psel && penable && paddr > 32'hC |-> pslverr) else $error("slverr");
endmodule
bind serial_pin_select_and_baud serial_pin_assertions chk (.*);
`default_nettype wire

// *** test/tb.sv ***
// Purpose: Self-checking bench for pin select
// Assumes: Zero-wait APB slave
// Notes: Reset read first, then routing rows, then hand tests
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, sub_clk_tick, e;
	logic low_power_mode, cpu_on_sub_div2, ch1_engine_tx, ch2_engine_tx, ch1_engine_rx;
	logic ch2_engine_rx, ch1_receive_line, ch2_receive_line, ch1_gpio_out, timer_output_line;
	logic timer_out_select, ch2_gpio_out, ch1_transmit_line, ch2_transmit_line;
	logic serial_run_allow, sync_bit_tick, sync_bit_clk;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [3:0] pstrb;
	logic [3:0] o;
	logic [1:0] sc = 2'h0;
	int n_errors = 0, n_tests = 0, n;
	logic [19:0] rows [6] = '{20'h00A02, 20'h3FA05, 20'h30707, 20'h00068, 20'h0FC9F, 20'h24405};
	serial_pin_select_and_baud dut (.*);
	assign o = {ch1_transmit_line, ch2_transmit_line, ch1_engine_rx, ch2_engine_rx};
	initial
	begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		sc <= sc + 2'h1;
		sub_clk_tick <= sc == 2'h3;
	end
	initial
	begin
		#50000;
		n_errors++;
		wrap_up;
	end
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic gap(output int c);
		do @(posedge pclk); while (sync_bit_tick !== 1'h1);
		c = 0;
		do
		begin
			@(posedge pclk);
			c++;
		end
		while (sync_bit_tick !== 1'h1);
	endtask
	task automatic wrap_up;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		{presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
		{low_power_mode, cpu_on_sub_div2, ch1_engine_tx, ch2_engine_tx, ch1_receive_line} = '0;
		{ch2_receive_line, ch1_gpio_out, timer_output_line, timer_out_select, ch2_gpio_out} = '0;
		pstrb = 4'hF;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		clk_en <= 1'h1;
		apb(1'h0, 32'h0, 32'h0);
		chk(r, 32'hC0);
		foreach (rows[i])
		begin
			apb(1'h1, 32'h0, {24'h0, rows[i][19:12]});
			{ch1_engine_tx, ch2_engine_tx, ch1_receive_line, ch2_receive_line, ch1_gpio_out,
				timer_output_line, timer_out_select, ch2_gpio_out} <= rows[i][11:4];
			apb(1'h0, 32'h0, 32'h0);
			chk(r, {24'h0, 2'h3, rows[i][17:12]});
			chk({28'h0, o}, {28'h0, rows[i][3:0]});
		end
		clk_en <= 1'h0;
		apb(1'h1, 32'h0, 32'h3F);
		clk_en <= 1'h1;
		apb(1'h0, 32'h10, 32'h0);
		chk({r[30:0], e}, 32'h1);
		apb(1'h0, 32'h0, 32'h0);
		chk(r, 32'hE4);
		for (int k = 0; k < 4; k++)
		begin
			{low_power_mode, cpu_on_sub_div2} <= k[1:0];
			repeat (2) @(posedge pclk);
			chk({31'h0, serial_run_allow}, {31'h0, k != 2});
		end
		for (int k = 0; k < 4; k++)
		begin
			apb(1'h1, 32'h8, k == 0 ? 32'h2 : 32'h0);
			apb(1'h1, 32'h4, 32'h4 + k);
			gap(n);
			gap(n);
			chk(n, k == 0 ? 12 : k == 1 ? 32 : k == 2 ? 64 : 256);
		end
		presetn <= 1'h0;
		@(posedge pclk);
		chk({31'h0, sync_bit_clk}, 32'h1);
		presetn <= 1'h1;
		apb(1'h0, 32'h0, 32'h0);
		chk(r, 32'hC0);
		apb(1'h0, 32'hC, 32'h0);
		chk(r, 32'h6);
		wrap_up;
	end
endmodule
`default_nettype wire
